// ===== acrt_consts.svh
`ifndef ACRT_CONSTS_SVH
`define ACRT_CONSTS_SVH

// ----------------------------------------------------------------
// widths and pin positions in the synchroniser vector
// ----------------------------------------------------------------
`define ACRT_RESULT_W 16
`define ACRT_PIN_W 13
`define ACRT_PIN_CNV 0
`define ACRT_PIN_CS 1
`define ACRT_PIN_SCK 2
`define ACRT_PIN_FAST 3
`define ACRT_PIN_LOWP 4
`define ACRT_PIN_SER 5
`define ACRT_PIN_CODE 6
`define ACRT_PIN_SWAP 7
`define ACRT_PIN_MSTR 8
`define ACRT_PIN_RDC 9
`define ACRT_PIN_DIV0 10
`define ACRT_PIN_DIV1 11
`define ACRT_PIN_SERIAL_DATA_IN 12
`define ACRT_FIFO_DEPTH 8

// ----------------------------------------------------------------
// clock and rounding helpers
// ----------------------------------------------------------------
`define ACRT_CLK_NS 10
`define ACRT_CLK_PS 10000
`define ACRT_CEIL(t, p) (((t) + (p) - 1) / (p))
`define ACRT_FLOOR(t, p) ((t) / (p))

// ----------------------------------------------------------------
// conversion and busy timing
// ----------------------------------------------------------------
`define ACRT_T_CONV_FAST_NS 750
`define ACRT_T_CONV_NORM_NS 1000
`define ACRT_T_CONV_LOWP_NS 1250
`define ACRT_T_DV_TO_BUSY_NS 20
`define ACRT_T_FRAME_TO_BUSY_NS 25
`define ACRT_SYNC_LAT_CYC 4
`define ACRT_FIFO_LAT_CYC 1
`define ACRT_DV_TO_BUSY_CYC `ACRT_CEIL(`ACRT_T_DV_TO_BUSY_NS, `ACRT_CLK_NS)
`define ACRT_SETTLE_CYC (`ACRT_FIFO_LAT_CYC + `ACRT_DV_TO_BUSY_CYC)
`define ACRT_CONV_FAST_CYC (`ACRT_FLOOR(`ACRT_T_CONV_FAST_NS, `ACRT_CLK_NS) - `ACRT_SYNC_LAT_CYC - `ACRT_SETTLE_CYC)
`define ACRT_CONV_NORM_CYC (`ACRT_FLOOR(`ACRT_T_CONV_NORM_NS, `ACRT_CLK_NS) - `ACRT_SYNC_LAT_CYC - `ACRT_SETTLE_CYC)
`define ACRT_CONV_LOWP_CYC (`ACRT_FLOOR(`ACRT_T_CONV_LOWP_NS, `ACRT_CLK_NS) - `ACRT_SYNC_LAT_CYC - `ACRT_SETTLE_CYC)
`define ACRT_BUSY_TAIL_CYC `ACRT_CEIL(`ACRT_T_FRAME_TO_BUSY_NS, `ACRT_CLK_NS)

// ----------------------------------------------------------------
// master serial clock timing per divider setting
// ----------------------------------------------------------------
`define ACRT_T_HI0_NS 15
`define ACRT_T_HI1_NS 25
`define ACRT_T_HI2_NS 50
`define ACRT_T_HI3_NS 100
`define ACRT_T_LO0_PS 9500
`define ACRT_T_LO1_NS 24
`define ACRT_T_LO2_NS 49
`define ACRT_T_LO3_NS 99
`define ACRT_T_LEAD0_NS 4
`define ACRT_T_LEAD_NS 20
`define ACRT_T_TAIL0_NS 3
`define ACRT_T_TAIL1_NS 60
`define ACRT_T_TAIL2_NS 140
`define ACRT_T_TAIL3_NS 300
`define ACRT_HI0_CYC `ACRT_CEIL(`ACRT_T_HI0_NS, `ACRT_CLK_NS)
`define ACRT_HI1_CYC `ACRT_CEIL(`ACRT_T_HI1_NS, `ACRT_CLK_NS)
`define ACRT_HI2_CYC `ACRT_CEIL(`ACRT_T_HI2_NS, `ACRT_CLK_NS)
`define ACRT_HI3_CYC `ACRT_CEIL(`ACRT_T_HI3_NS, `ACRT_CLK_NS)
`define ACRT_LO0_CYC `ACRT_CEIL(`ACRT_T_LO0_PS, `ACRT_CLK_PS)
`define ACRT_LO1_CYC `ACRT_CEIL(`ACRT_T_LO1_NS, `ACRT_CLK_NS)
`define ACRT_LO2_CYC `ACRT_CEIL(`ACRT_T_LO2_NS, `ACRT_CLK_NS)
`define ACRT_LO3_CYC `ACRT_CEIL(`ACRT_T_LO3_NS, `ACRT_CLK_NS)
`define ACRT_LEAD0_CYC `ACRT_CEIL(`ACRT_T_LEAD0_NS, `ACRT_CLK_NS)
`define ACRT_LEAD_CYC `ACRT_CEIL(`ACRT_T_LEAD_NS, `ACRT_CLK_NS)
`define ACRT_TAIL0_CYC `ACRT_CEIL(`ACRT_T_TAIL0_NS, `ACRT_CLK_NS)
`define ACRT_TAIL1_CYC `ACRT_CEIL(`ACRT_T_TAIL1_NS, `ACRT_CLK_NS)
`define ACRT_TAIL2_CYC `ACRT_CEIL(`ACRT_T_TAIL2_NS, `ACRT_CLK_NS)
`define ACRT_TAIL3_CYC `ACRT_CEIL(`ACRT_T_TAIL3_NS, `ACRT_CLK_NS)

`endif

// ===== acrt_pkg.sv
`include "acrt_consts.svh"

package acrt_pkg;

  typedef logic [1:0] acrt_div_t;
  typedef logic [`ACRT_RESULT_W-1:0] acrt_word_t;

  typedef enum logic [2:0] {C_IDLE, C_CONV, C_SETTLE, C_WAIT_SER, C_TAIL} acrt_conv_state_t;
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_HIGH, S_LOW, S_TAIL} acrt_ser_state_t;

  typedef struct packed {
    logic [`ACRT_PIN_W-1:0] s1;
    logic [`ACRT_PIN_W-1:0] s2;
    logic [`ACRT_PIN_W-1:0] s3;
    logic [`ACRT_PIN_W-1:0] filt;
    acrt_conv_state_t cst;
    logic [7:0] ctmr;
    logic busy;
    acrt_ser_state_t sst;
    logic [7:0] stmr;
    logic [4:0] sbit;
    acrt_word_t sshift;
    logic frame;
    logic sclk;
    logic sdo;
    acrt_word_t out_word;
    logic out_full;
    acrt_word_t par;
    logic lact;
    logic [4:0] lbit;
    acrt_word_t lshift;
  } acrt_state_t;

endpackage : acrt_pkg

// ===== acrt_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none

interface acrt_fifo_if #(
  parameter int WIDTH = 16
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo (
    input push_valid,
    input push_data,
    input pop_ready,
    output push_ready,
    output pop_valid,
    output pop_data
  );

  modport user (
    output push_valid,
    output push_data,
    output pop_ready,
    input push_ready,
    input pop_valid,
    input pop_data
  );
endinterface : acrt_fifo_if

`default_nettype wire

// ===== acrt_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module acrt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // queue ports
  acrt_fifo_if.fifo q
);
  import acrt_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } acrt_fifo_state_t;

  acrt_fifo_state_t st_q;
  acrt_fifo_state_t st_d;
  logic do_push;
  logic do_pop;

  // honest flags: full stalls the filling side, empty hides stale data
  assign q.push_ready = (st_q.cnt != FULL);
  assign q.pop_valid = (st_q.cnt != '0);
  assign q.pop_data = st_q.mem[st_q.rd];
  assign do_push = q.push_valid && q.push_ready;
  assign do_pop = q.pop_valid && q.pop_ready;

  always_comb
  begin
    st_d = st_q;
    if (do_push)
    begin
      st_d.mem[st_q.wr] = q.push_data;
      st_d.wr = (st_q.wr == LAST) ? '0 : AW'(st_q.wr + 1'b1);
    end
    if (do_pop)
    begin
      st_d.rd = (st_q.rd == LAST) ? '0 : AW'(st_q.rd + 1'b1);
    end
    if (do_push && !do_pop)
    begin
      st_d.cnt = CW'(st_q.cnt + 1'b1);
    end
    else if (do_pop && !do_push)
    begin
      st_d.cnt = CW'(st_q.cnt - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule : acrt_fifo

`default_nettype wire

// ===== acrt_readout.sv
// Overview of operation
// - conversion finishes within 0.75/1/1.25 us
// - busy high bounded by rate mode
// - parallel result valid within conversion time
// - data valid 20 ns before busy falls
// - divider select sets serial clock period
// - serial clock high and low minimums
// - frame lead before first serial edge
// - frame held after last serial edge
// - read-after-convert busy bounded per divider
// - read-after frame only after conversion done
// - busy ends shortly after frame drops
// - read-during frame follows convert start
// - deselect releases master serial outputs
// - select drives serial clock output
// - slave shifts on host clock edge
// - serial select picks serial or parallel
// - code select inverts msb for twos complement
// - byte order select swaps bus bytes
`timescale 1ns/100ps
`default_nettype none
`include "acrt_consts.svh"

module acrt_readout #(
  parameter int FIFO_DEPTH = `ACRT_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // conversion control
  input wire logic convert_start_n,
  output logic busy,
  // rate and format straps
  input wire logic fastest_rate_mode,
  input wire logic low_power_rate_mode,
  input wire logic serial_parallel_select,
  input wire logic output_code_select,
  input wire logic byte_order_select,
  input wire logic serial_master_select,
  input wire logic read_during_convert,
  input wire acrt_pkg::acrt_div_t clock_divider_select,
  // sampled result from the analog core
  input wire acrt_pkg::acrt_word_t sar_result,
  // parallel port
  output acrt_pkg::acrt_word_t parallel_data,
  output logic parallel_data_oe,
  // serial port
  input wire logic device_select_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic frame_marker,
  output logic frame_marker_oe,
  output logic serial_clock_out,
  output logic serial_clock_out_oe
);
  import acrt_pkg::*;

  // ----------------------------------------------------------------
  // per-divider serial timing
  // ----------------------------------------------------------------
  function automatic logic [7:0] hi_cyc(input acrt_div_t d);
    logic [7:0] r;
    unique case (d)
      2'h0: r = 8'(`ACRT_HI0_CYC);
      2'h1: r = 8'(`ACRT_HI1_CYC);
      2'h2: r = 8'(`ACRT_HI2_CYC);
      2'h3: r = 8'(`ACRT_HI3_CYC);
    endcase
    return r;
  endfunction : hi_cyc

  function automatic logic [7:0] lo_cyc(input acrt_div_t d);
    logic [7:0] r;
    unique case (d)
      2'h0: r = 8'(`ACRT_LO0_CYC);
      2'h1: r = 8'(`ACRT_LO1_CYC);
      2'h2: r = 8'(`ACRT_LO2_CYC);
      2'h3: r = 8'(`ACRT_LO3_CYC);
    endcase
    return r;
  endfunction : lo_cyc

  function automatic logic [7:0] tail_cyc(input acrt_div_t d);
    logic [7:0] r;
    unique case (d)
      2'h0: r = 8'(`ACRT_TAIL0_CYC);
      2'h1: r = 8'(`ACRT_TAIL1_CYC);
      2'h2: r = 8'(`ACRT_TAIL2_CYC);
      2'h3: r = 8'(`ACRT_TAIL3_CYC);
    endcase
    return r;
  endfunction : tail_cyc

  // ----------------------------------------------------------------
  // state, result queue and decoded pins
  // ----------------------------------------------------------------
  acrt_state_t st_q;
  acrt_state_t st_d;
  acrt_fifo_if #(.WIDTH(`ACRT_RESULT_W)) rq ();

  acrt_fifo #(
    .WIDTH(`ACRT_RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .q(rq.fifo)
  );

  logic [`ACRT_PIN_W-1:0] pins;
  logic [`ACRT_PIN_W-1:0] agree;
  logic start_fall;
  logic sck_fall;
  logic ser_mode;
  logic master;
  logic cs_active;
  logic rd_during;
  logic code_bin;
  logic swap;
  acrt_div_t div;
  logic [7:0] conv_cyc;
  logic ser_go;
  acrt_word_t coded;

  assign pins = {serial_data_in, clock_divider_select, read_during_convert, serial_master_select,
                 byte_order_select, output_code_select, serial_parallel_select, low_power_rate_mode,
                 fastest_rate_mode, serial_clock_in, device_select_n, convert_start_n};
  assign agree = ~(st_q.s2 ^ st_q.s3);
  // a falling edge counts once the second and third stages agree low
  assign start_fall = st_q.filt[`ACRT_PIN_CNV] && agree[`ACRT_PIN_CNV] && !st_q.s3[`ACRT_PIN_CNV];
  assign sck_fall = st_q.filt[`ACRT_PIN_SCK] && agree[`ACRT_PIN_SCK] && !st_q.s3[`ACRT_PIN_SCK];
  assign ser_mode = st_q.filt[`ACRT_PIN_SER];
  assign master = st_q.filt[`ACRT_PIN_MSTR];
  assign cs_active = !st_q.filt[`ACRT_PIN_CS];
  assign rd_during = st_q.filt[`ACRT_PIN_RDC];
  assign code_bin = st_q.filt[`ACRT_PIN_CODE];
  assign swap = st_q.filt[`ACRT_PIN_SWAP];
  assign div = {st_q.filt[`ACRT_PIN_DIV1], st_q.filt[`ACRT_PIN_DIV0]};

  // ----------------------------------------------------------------
  // rate decode
  // ----------------------------------------------------------------
  always_comb
  begin
    conv_cyc = 8'(`ACRT_CONV_NORM_CYC);
    if (st_q.filt[`ACRT_PIN_FAST] && !st_q.filt[`ACRT_PIN_LOWP])
    begin
      conv_cyc = 8'(`ACRT_CONV_FAST_CYC);
    end
    else if (st_q.filt[`ACRT_PIN_LOWP] && !st_q.filt[`ACRT_PIN_FAST])
    begin
      conv_cyc = 8'(`ACRT_CONV_LOWP_CYC);
    end
  end

  assign coded = {sar_result[`ACRT_RESULT_W-1] ^ !code_bin, sar_result[`ACRT_RESULT_W-2:0]};

  // the queue refuses a start when full, so a result is never dropped
  assign rq.push_valid = (st_q.cst == C_CONV) && (st_q.ctmr == '0);
  assign rq.push_data = coded;
  assign rq.pop_ready = !st_q.out_full;

  always_comb
  begin
    ser_go = 1'b0;
    if (ser_mode && master && st_q.sst == S_IDLE && st_q.out_full)
    begin
      if (rd_during)
      begin
        ser_go = (st_q.cst == C_IDLE) && start_fall && rq.push_ready;
      end
      else
      begin
        ser_go = (st_q.cst == C_SETTLE) && (st_q.ctmr == '0);
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.filt = (agree & st_q.s3) | (~agree & st_q.filt);

    // conversion sequencer
    unique case (st_q.cst)
      C_IDLE:
      begin
        if (start_fall && rq.push_ready)
        begin
          st_d.cst = C_CONV;
          st_d.ctmr = conv_cyc - 8'h01;
        end
      end
      C_CONV:
      begin
        if (st_q.ctmr == '0)
        begin
          st_d.cst = C_SETTLE;
          st_d.ctmr = 8'(`ACRT_SETTLE_CYC - 1);
        end
        else
        begin
          st_d.ctmr = st_q.ctmr - 8'h01;
        end
      end
      C_SETTLE:
      begin
        if (st_q.ctmr != '0)
        begin
          st_d.ctmr = st_q.ctmr - 8'h01;
        end
        else if (ser_mode && master && !rd_during)
        begin
          st_d.cst = C_WAIT_SER;
        end
        else
        begin
          st_d.cst = C_IDLE;
        end
      end
      C_WAIT_SER:
      begin
        if (st_q.sst == S_IDLE)
        begin
          st_d.cst = C_TAIL;
          st_d.ctmr = 8'(`ACRT_BUSY_TAIL_CYC - 1);
        end
      end
      C_TAIL:
      begin
        if (st_q.ctmr == '0)
        begin
          st_d.cst = C_IDLE;
        end
        else
        begin
          st_d.ctmr = st_q.ctmr - 8'h01;
        end
      end
    endcase
    st_d.busy = (st_d.cst != C_IDLE);

    // output stage: parallel mode overwrites, serial holds until shifted out
    if (rq.pop_valid && rq.pop_ready)
    begin
      st_d.out_word = rq.pop_data;
      st_d.out_full = ser_mode;
      st_d.par = swap ? {rq.pop_data[7:0], rq.pop_data[15:8]} : rq.pop_data;
    end

    // master serial engine
    unique case (st_q.sst)
      S_IDLE:
      begin
        if (ser_go)
        begin
          st_d.sst = S_LEAD;
          st_d.frame = 1'b1;
          st_d.sclk = 1'b0;
          st_d.sshift = st_q.out_word;
          st_d.sbit = '0;
          st_d.stmr = ((div == 2'h0) ? 8'(`ACRT_LEAD0_CYC) : 8'(`ACRT_LEAD_CYC)) - 8'h01;
        end
      end
      S_LEAD:
      begin
        if (st_q.stmr == '0)
        begin
          st_d.sst = S_HIGH;
          st_d.sclk = 1'b1;
          st_d.stmr = hi_cyc(div) - 8'h01;
        end
        else
        begin
          st_d.stmr = st_q.stmr - 8'h01;
        end
      end
      S_HIGH:
      begin
        if (st_q.stmr != '0)
        begin
          st_d.stmr = st_q.stmr - 8'h01;
        end
        else if (st_q.sbit == 5'(`ACRT_RESULT_W - 1))
        begin
          st_d.sst = S_TAIL;
          st_d.sclk = 1'b0;
          st_d.stmr = tail_cyc(div) - 8'h01;
        end
        else
        begin
          st_d.sst = S_LOW;
          st_d.sclk = 1'b0;
          st_d.sshift = {st_q.sshift[`ACRT_RESULT_W-2:0], 1'b0};
          st_d.sbit = st_q.sbit + 5'h01;
          st_d.stmr = lo_cyc(div) - 8'h01;
        end
      end
      S_LOW:
      begin
        if (st_q.stmr == '0)
        begin
          st_d.sst = S_HIGH;
          st_d.sclk = 1'b1;
          st_d.stmr = hi_cyc(div) - 8'h01;
        end
        else
        begin
          st_d.stmr = st_q.stmr - 8'h01;
        end
      end
      S_TAIL:
      begin
        if (st_q.stmr == '0)
        begin
          st_d.sst = S_IDLE;
          st_d.frame = 1'b0;
          st_d.out_full = 1'b0;
        end
        else
        begin
          st_d.stmr = st_q.stmr - 8'h01;
        end
      end
    endcase

    // slave serial engine
    if (ser_mode && !master)
    begin
      if (!st_q.lact && st_q.out_full)
      begin
        st_d.lact = 1'b1;
        st_d.lshift = st_q.out_word;
        st_d.lbit = '0;
      end
      else if (st_q.lact && sck_fall)
      begin
        st_d.lshift = {st_q.lshift[`ACRT_RESULT_W-2:0], st_q.filt[`ACRT_PIN_SERIAL_DATA_IN]};
        st_d.lbit = st_q.lbit + 5'h01;
        if (st_q.lbit == 5'(`ACRT_RESULT_W - 1))
        begin
          st_d.lact = 1'b0;
          st_d.out_full = 1'b0;
        end
      end
    end
    else
    begin
      st_d.lact = 1'b0;
    end
    st_d.sdo = master ? st_d.sshift[`ACRT_RESULT_W-1] : st_d.lshift[`ACRT_RESULT_W-1];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign busy = st_q.busy;
  assign parallel_data = st_q.par;
  assign serial_data_out = st_q.sdo;
  assign frame_marker = st_q.frame;
  assign serial_clock_out = st_q.sclk;
  assign parallel_data_oe = !ser_mode && cs_active;
  assign serial_clock_out_oe = ser_mode && master && cs_active;
  assign frame_marker_oe = ser_mode && master && cs_active;
  assign serial_data_out_oe = ser_mode && cs_active;
endmodule : acrt_readout

`default_nettype wire

// ===== acrt_readout_properties.sv
`timescale 1ns/100ps
`default_nettype none

module acrt_readout_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pins
  input wire logic convert_start_n,
  input wire logic busy,
  input wire logic fastest_rate_mode,
  input wire logic low_power_rate_mode,
  input wire logic serial_parallel_select,
  input wire logic serial_master_select,
  input wire logic read_during_convert,
  input wire acrt_pkg::acrt_div_t clock_divider_select,
  input wire acrt_pkg::acrt_word_t parallel_data,
  input wire logic parallel_data_oe,
  input wire logic device_select_n,
  input wire logic frame_marker,
  input wire logic frame_marker_oe,
  input wire logic serial_clock_out,
  input wire logic serial_clock_out_oe
);
  import acrt_pkg::*;
  // -------------------------------
  // cycle limits per divider
  // -------------------------------
  localparam int HMIN [4] = '{2, 3, 5, 10};
  localparam int PMIN [4] = '{3, 5, 10, 20};
  localparam int PMAX [4] = '{4, 7, 14, 28};
  localparam int TAIL [4] = '{1, 6, 14, 30};
  logic [7:0] bcnt_q;
  logic [5:0] hi_q;
  logic [5:0] per_q;
  logic [5:0] gap_q;
  logic [7:0] lim;
  logic mra;
  assign lim = (fastest_rate_mode && !low_power_rate_mode) ? 8'h4B : (low_power_rate_mode && !fastest_rate_mode) ? 8'h7D : 8'h64;
  assign mra = serial_parallel_select && serial_master_select && !read_during_convert;
  // busy, period and gap counters saturate so long idle gaps never wrap into a false short period
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bcnt_q <= 8'h00;
      hi_q <= 6'h00;
      per_q <= 6'h3F;
      gap_q <= 6'h3F;
    end
    else
    begin
      bcnt_q <= busy ? bcnt_q + {7'h00, bcnt_q != 8'hFF} : 8'h00;
      hi_q <= serial_clock_out ? hi_q + 6'h01 : 6'h00;
      per_q <= (serial_clock_out && hi_q == 6'h00) ? 6'h01 : per_q + {5'h00, per_q != 6'h3F};
      gap_q <= (!serial_clock_out && hi_q != 6'h00) ? 6'h01 : gap_q + {5'h00, gap_q != 6'h3F};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence lead_s;
    !serial_clock_out ##1 (clock_divider_select == 2'h0 || !serial_clock_out);
  endsequence
  sequence tail_s;
    busy [*2] ##[1:3] !busy;
  endsequence
  busy_width_a: assert property (busy && !mra |-> bcnt_q < lim)
    else $error("busy high too long");
  start_busy_a: assert property ($fell(convert_start_n) && !busy && !serial_parallel_select |-> ##[3:6] busy)
    else $error("start did not raise busy");
  data_settle_a: assert property ($fell(busy) && !serial_parallel_select |-> parallel_data == $past(parallel_data))
    else $error("data changed close to busy fall");
  frame_late_a: assert property ($rose(frame_marker) && !read_during_convert |-> busy && bcnt_q >= lim - 8'h0A)
    else $error("frame before conversion end");
  frame_lead_a: assert property ($rose(frame_marker) |-> lead_s)
    else $error("serial clock too soon after frame");
  sclk_high_a: assert property ($fell(serial_clock_out) |-> hi_q >= HMIN[clock_divider_select])
    else $error("serial clock high too short");
  sclk_period_a: assert property ($rose(serial_clock_out) && per_q != 6'h3F |-> per_q inside {[PMIN[clock_divider_select]:PMAX[clock_divider_select]]})
    else $error("serial clock period out of range");
  frame_hold_a: assert property ($fell(frame_marker) |-> gap_q >= TAIL[clock_divider_select])
    else $error("frame dropped too soon");
  busy_tail_a: assert property ($fell(frame_marker) && mra |-> tail_s)
    else $error("busy end not tied to frame end");
  desel_release_a: assert property (device_select_n [*8] |-> !serial_clock_out_oe && !frame_marker_oe)
    else $error("serial lines driven while deselected");
  sel_drive_a: assert property ((!device_select_n && serial_parallel_select && serial_master_select) [*8] |-> serial_clock_out_oe)
    else $error("serial clock not driven when selected");
  par_release_a: assert property (serial_parallel_select [*8] |-> !parallel_data_oe)
    else $error("parallel bus driven in serial mode");
endmodule : acrt_readout_chk

bind acrt_readout acrt_readout_chk u_chk (.core_clk, .arst_n, .convert_start_n, .busy, .fastest_rate_mode,
  .low_power_rate_mode, .serial_parallel_select, .serial_master_select, .read_during_convert, .clock_divider_select,
  .parallel_data, .parallel_data_oe, .device_select_n, .frame_marker, .frame_marker_oe, .serial_clock_out,
  .serial_clock_out_oe);

`default_nettype wire

// ===== acrt_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module acrt_host_model (
  // lines from the converter
  input wire logic sclk_w,
  input wire logic frame_w,
  input wire logic sdo_w,
  // slave read request and clock
  input wire logic slave_go,
  output logic serial_clock_in,
  // last word read
  output acrt_pkg::acrt_word_t word,
  output int words
);
  import acrt_pkg::*;
  acrt_word_t sh;
  initial
  begin
    serial_clock_in = 1'b1;
    word = 16'h0000;
    sh = 16'h0000;
    words = 0;
  end
  // master data taken on clock rise
  always @(posedge sclk_w)
  begin
    if (frame_w)
      sh = {sh[14:0], sdo_w};
  end
  always @(negedge frame_w)
  begin
    word = sh;
    words++;
  end
  // falling edge shifts
  // clock stands high between reads; bit is taken just before the edge that moves it
  always @(posedge slave_go)
  begin
    repeat (16)
    begin
      #100;
      sh = {sh[14:0], sdo_w};
      serial_clock_in = 1'b0;
      #100;
      serial_clock_in = 1'b1;
    end
    word = sh;
    words++;
  end
endmodule : acrt_host_model

`default_nettype wire

// ===== acrt_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none

module acrt_readout_tb;
  import acrt_pkg::*;
  localparam int LIM [4] = '{100, 125, 75, 100};
  localparam int BMAX [4] = '{175, 225, 325, 550};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic convert_start_n = 1'b1;
  logic fastest_rate_mode = 1'b0, low_power_rate_mode = 1'b0, serial_parallel_select = 1'b0;
  logic output_code_select = 1'b1, byte_order_select = 1'b0, serial_master_select = 1'b0;
  logic read_during_convert = 1'b0, device_select_n = 1'b0, serial_data_in = 1'b0, slave_go = 1'b0;
  acrt_div_t clock_divider_select = 2'h0;
  acrt_word_t sar_result = 16'h0000, parallel_data, word, w;
  logic busy, parallel_data_oe, serial_data_out, serial_data_out_oe, frame_marker, frame_marker_oe;
  logic serial_clock_out, serial_clock_out_oe, serial_clock_in, sdo_last = 1'b0;
  int err_total = 0, total_checks = 0, words, n, k;
  acrt_word_t q[$];
  // a released data line shows the inverse of its last level
  wire logic sdo_w = serial_data_out_oe ? serial_data_out : ~sdo_last;
  wire logic sclk_w = serial_clock_out_oe & serial_clock_out;
  wire logic frame_w = frame_marker_oe & frame_marker;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (serial_data_out_oe)
      sdo_last <= serial_data_out;
  end
  acrt_readout dut (.core_clk, .arst_n, .convert_start_n, .busy, .fastest_rate_mode, .low_power_rate_mode,
    .serial_parallel_select, .output_code_select, .byte_order_select, .serial_master_select, .read_during_convert,
    .clock_divider_select, .sar_result, .parallel_data, .parallel_data_oe, .device_select_n, .serial_clock_in,
    .serial_data_in, .serial_data_out, .serial_data_out_oe, .frame_marker, .frame_marker_oe, .serial_clock_out,
    .serial_clock_out_oe);
  acrt_host_model host (.sclk_w, .frame_w, .sdo_w, .slave_go, .serial_clock_in, .word, .words);
  // -------------------------------
  // access tasks
  // -------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic ok(input logic c);
    check({15'h0000, c}, 16'h0001);
  endtask : ok
  task automatic cfg(input logic [6:0] p, input acrt_div_t d);
    {fastest_rate_mode, low_power_rate_mode, serial_parallel_select, serial_master_select, read_during_convert,
      output_code_select, byte_order_select} = p;
    clock_divider_select = d;
    tick(8);
  endtask : cfg
  task automatic start();
    convert_start_n = 1'b0;
    tick(2);
    convert_start_n = 1'b1;
  endtask : start
  // n counts edges since the pin fell; a refused start leaves n at 6
  task automatic idle(inout int c);
    do
    begin
      tick(1);
      c++;
    end
    while ((busy !== 1'b0 || c < 6) && c < 3000);
  endtask : idle
  task automatic run(input acrt_word_t v, output int c);
    sar_result = v;
    start();
    c = 2;
    idle(c);
  endtask : run
  function automatic acrt_word_t pexp(input acrt_word_t v, input logic ob, input logic sw);
    acrt_word_t x;
    x = v ^ {~ob, 15'h0000};
    return sw ? {x[7:0], x[15:8]} : x;
  endfunction : pexp
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    tick(16);
    arst_n = 1'b1;
    tick(5);
    // mode pairs, code and byte order all varied; both rate pins high falls back to normal rate
    for (int m = 0; m < 4; m++)
    begin
      cfg({m[1], m[0], 3'b000, m[0] ^ m[1], m[1]}, 2'h0);
      w = 16'hC35A + 16'(m);
      run(w, n);
      ok(n <= LIM[m] && n > LIM[m] - 25);
      check(parallel_data, pexp(w, m[0] ^ m[1], m[1]));
      ok(parallel_data_oe);
    end
    $display("parallel modes done");
    // second start deliberately inside the busy window
    cfg(7'b0000010, 2'h0);
    sar_result = 16'h1234;
    start();
    tick(20);
    start();
    n = 30;
    idle(n);
    tick(10);
    check(parallel_data, 16'h1234);
    ok(busy === 1'b0);
    $display("busy refusal done");
    for (int d = 0; d < 4; d++)
    begin
      cfg(7'b0011010, 2'(d));
      k = words;
      w = 16'hA5C3 ^ 16'(d * 16'h1111);
      run(w, n);
      ok(n <= BMAX[d]);
      check(word, w);
      ok(words == k + 1);
    end
    $display("master read after done");
    cfg(7'b0011110, 2'h0);
    k = words;
    run(16'h0F0F, n);
    ok(words == k);
    sar_result = 16'h7E81;
    start();
    n = 2;
    while (frame_marker !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    ok(n <= 8);
    idle(n);
    check(word, 16'h0F0F);
    device_select_n = 1'b1;
    tick(8);
    ok(!serial_clock_out_oe && !frame_marker_oe && !serial_data_out_oe);
    device_select_n = 1'b0;
    tick(8);
    ok(serial_clock_out_oe && frame_marker_oe);
    $display("read during and select done");
    cfg(7'b0010010, 2'h0);
    q = '{16'h7E81};
    for (int i = 0; i < 12; i++)
    begin
      w = 16'h3C00 + 16'(i);
      run(w, n);
      if (n < 10)
        break;
      q.push_back(w);
    end
    ok(q.size() >= 8 && q.size() <= 9);
    while (q.size() > 0)
    begin
      k = words;
      slave_go = 1'b1;
      tick(1);
      slave_go = 1'b0;
      n = 0;
      while (words == k && n < 600)
      begin
        tick(1);
        n++;
      end
      tick(10);
      check(word, q.pop_front());
    end
    run(16'h0001, n);
    ok(n > 10);
    $display("slave and buffer done");
    finish_test();
  end
endmodule : acrt_readout_tb

`default_nettype wire
